// *** rtl/aea_pkg.sv ***
`default_nettype none

package aea_pkg;

	// Widths
	localparam int ACC_W = 49;
	localparam int ENERGY_W = 24;
	localparam int PHASE_W = 24;
	localparam int TERM_W = 26;
	localparam int SUM_W = 28;
	localparam int GAIN_W = 12;
	localparam int GAIN_FRAC = 12;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;
	localparam int HC_W = 16;

	// Accumulator tick: one sample per this many clocks
	localparam int SAMPLE_CYCLES = 12;
	localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CYCLES - 1);

	// Register addresses
	localparam logic [5:0] ADDR_MEAS_MODE = 6'h0b;
	localparam logic [5:0] ADDR_WAVE_MODE = 6'h0c;
	localparam logic [5:0] ADDR_ACT_MODE = 6'h0d;
	localparam logic [5:0] ADDR_APP_MODE = 6'h0e;
	localparam logic [5:0] ADDR_IRQ_EN = 6'h0f;
	localparam logic [5:0] ADDR_IRQ_STAT = 6'h10;
	localparam logic [5:0] ADDR_HALF_CYC = 6'h12;
	localparam logic [5:0] ADDR_APP_ENERGY = 6'h13;
	localparam logic [5:0] ADDR_APP_RCLR = 6'h14;
	localparam logic [5:0] ADDR_LINE_APP = 6'h15;
	localparam logic [5:0] ADDR_LINE_ACT = 6'h16;
	localparam logic [5:0] ADDR_DIVISOR = 6'h17;
	localparam logic [5:0] ADDR_GAIN_A = 6'h18;
	localparam logic [5:0] ADDR_GAIN_B = 6'h19;
	localparam logic [5:0] ADDR_GAIN_C = 6'h1a;

	// Field positions
	localparam int FORMULA_MSB = 7;
	localparam int FORMULA_LSB = 6;
	localparam int LINE_SEL_MSB = 5;
	localparam int LINE_SEL_LSB = 3;
	localparam int TERM_SEL_MSB = 2;
	localparam int TERM_SEL_LSB = 0;
	localparam int LINE_ACT_SEL_MSB = 2;
	localparam int LINE_ACT_SEL_LSB = 0;
	localparam int ZX_SEL_MSB = 6;
	localparam int ZX_SEL_LSB = 4;
	localparam int REACTIVE_BIT = 5;
	localparam int IRQ_HALF_FULL = 0;
	localparam int IRQ_CYCLE_DONE = 1;

	// Reset values
	localparam logic [7:0] RST_APP_MODE = 8'h3f;
	localparam logic [7:0] RST_ACT_MODE = 8'h07;
	localparam logic [7:0] RST_MEAS_MODE = 8'h70;
	localparam logic [7:0] RST_WAVE_MODE = 8'h00;
	localparam logic [7:0] RST_DIVISOR = 8'h00;
	localparam logic [15:0] RST_HALF_CYC = 16'hffff;
	localparam logic [1:0] RST_IRQ_EN = 2'h0;

	typedef enum logic [1:0] {
		AEA_F_PHASE = 2'b00,
		AEA_F_AVG = 2'b01,
		AEA_F_VA_IB = 2'b10
	} aea_formula_t;

endpackage

`default_nettype wire

// *** rtl/aea_power_sum.sv ***
`timescale 1ns/1ps
`default_nettype none

module aea_power_sum #(
	parameter int RMS_W = 16
) (
	input wire logic [RMS_W-1:0] v_a,
	input wire logic [RMS_W-1:0] v_b,
	input wire logic [RMS_W-1:0] v_c,
	input wire logic [RMS_W-1:0] i_a,
	input wire logic [RMS_W-1:0] i_b,
	input wire logic [RMS_W-1:0] i_c,
	input wire logic [aea_pkg::GAIN_W-1:0] gain_a,
	input wire logic [aea_pkg::GAIN_W-1:0] gain_b,
	input wire logic [aea_pkg::GAIN_W-1:0] gain_c,
	input wire logic [1:0] formula,
	input wire logic [2:0] term_sel,
	output logic signed [aea_pkg::SUM_W-1:0] total
);

	localparam int WIDE_W = aea_pkg::PHASE_W + 1 + aea_pkg::GAIN_W;

	// Phase power times (1 + gain / 2^12)
	function automatic logic signed [aea_pkg::TERM_W-1:0] gain_term(
		input logic [RMS_W-1:0] v,
		input logic [RMS_W-1:0] i,
		input logic [aea_pkg::GAIN_W-1:0] g
	);
		logic [2*RMS_W-1:0] prod;
		logic signed [aea_pkg::PHASE_W:0] p;
		logic signed [WIDE_W-1:0] wide;
		prod = v * i;
		p = $signed({1'b0, prod[2*RMS_W-1 -: aea_pkg::PHASE_W]});
		wide = WIDE_W'(p) + ((p * $signed(g)) >>> aea_pkg::GAIN_FRAC);
		return wide[aea_pkg::TERM_W-1:0];
	endfunction

	logic [RMS_W:0] v_avg_wide;
	logic [RMS_W-1:0] v_mid;
	logic signed [aea_pkg::TERM_W-1:0] t_a;
	logic signed [aea_pkg::TERM_W-1:0] t_b;
	logic signed [aea_pkg::TERM_W-1:0] t_c;

	always_comb
	begin
		v_avg_wide = {1'b0, v_a} + {1'b0, v_c};
		case (formula)
			aea_pkg::AEA_F_PHASE: v_mid = v_b;
			aea_pkg::AEA_F_AVG: v_mid = v_avg_wide[RMS_W:1];
			aea_pkg::AEA_F_VA_IB: v_mid = v_a;
			default: v_mid = v_b;
		endcase
		t_a = gain_term(v_a, i_a, gain_a);
		t_b = gain_term(v_mid, i_b, gain_b);
		t_c = gain_term(v_c, i_c, gain_c);
		total = '0;
		if (term_sel[0])
			total = total + aea_pkg::SUM_W'(t_a);
		if (term_sel[1])
			total = total + aea_pkg::SUM_W'(t_b);
		if (term_sel[2])
			total = total + aea_pkg::SUM_W'(t_c);
	end

endmodule // aea_power_sum

`default_nettype wire

// *** rtl/aea_top.sv ***
// Operation
// - Formula select in apparent mode bits 7:6
// - Formulas: per-phase, averaged Vb, or Va for B
// - Term select bit includes or drops term
// - Each term scaled by one plus gain/4096
// - Hidden 49-bit accumulator, 24-bit readable energy
// - One sample added every twelve clocks
// - Accumulator addition is signed
// - Divide by 8-bit divisor, zero means one
// - Read-clear energy copy zeroed by reads
// - Energy wraps to 800000 hex at divisor 0 or 1, keeps rising
// - Half-full energy event raises enabled interrupt
// - Line apparent accumulation always runs
// - Phase zero crossings counted per mode bits 4-6
// - Phase selection enables its zero-crossing logic
// - Sixteen-bit unsigned half-cycle count register
// - Cycle end sets flag, enabled interrupt low
// - Line path uses line term selects
// - Line path shares apparent energy scaling
// - Reactive mode redirects both line accumulators
// - Active energy in line apparent is unsigned
// - Reactive mode uses active line term selects
`timescale 1ns/1ps
`default_nettype none

module aea_top #(
	parameter int RMS_W = 16
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic [aea_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic [aea_pkg::DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [aea_pkg::DATA_W-1:0] REG_RDATA,
	input wire logic [RMS_W-1:0] V_RMS_A,
	input wire logic [RMS_W-1:0] V_RMS_B,
	input wire logic [RMS_W-1:0] V_RMS_C,
	input wire logic [RMS_W-1:0] I_RMS_A,
	input wire logic [RMS_W-1:0] I_RMS_B,
	input wire logic [RMS_W-1:0] I_RMS_C,
	input wire logic [aea_pkg::PHASE_W-1:0] ACT_PWR_A,
	input wire logic [aea_pkg::PHASE_W-1:0] ACT_PWR_B,
	input wire logic [aea_pkg::PHASE_W-1:0] ACT_PWR_C,
	input wire logic [aea_pkg::PHASE_W-1:0] REACT_PWR_A,
	input wire logic [aea_pkg::PHASE_W-1:0] REACT_PWR_B,
	input wire logic [aea_pkg::PHASE_W-1:0] REACT_PWR_C,
	input wire logic [2:0] ZERO_CROSS,
	output logic [2:0] ZX_ENABLE,
	output logic IRQ_N
);

	localparam int AW = aea_pkg::ACC_W;
	localparam int EW = aea_pkg::ENERGY_W;

	typedef struct packed {
		logic [3:0] tick_cnt;
		logic [7:0] wave_mode;
		logic [7:0] act_mode;
		logic [7:0] app_mode;
		logic [7:0] meas_mode;
		logic [7:0] divisor;
		logic [aea_pkg::HC_W-1:0] half_cyc;
		logic [aea_pkg::GAIN_W-1:0] gain_a;
		logic [aea_pkg::GAIN_W-1:0] gain_b;
		logic [aea_pkg::GAIN_W-1:0] gain_c;
		logic [1:0] irq_en;
		logic [1:0] irq_stat;
		logic [AW-1:0] app_acc;
		logic [AW-1:0] rc_acc;
		logic [AW-1:0] line_app_acc;
		logic [AW-1:0] line_act_acc;
		logic [EW-1:0] line_app_energy;
		logic [EW-1:0] line_act_energy;
		logic [aea_pkg::HC_W-1:0] hc_cnt;
		logic half_full_prev;
		logic [aea_pkg::DATA_W-1:0] rdata;
	} aea_state_t;

	aea_state_t r_reg;
	aea_state_t r_next;

	// Upper 24 bits of accumulator over divisor
	function automatic logic [EW-1:0] div_upper(
		input logic [AW-1:0] acc,
		input logic [7:0] div
	);
		logic signed [AW-1:0] q;
		logic signed [8:0] d;
		d = (div == 8'h00) ? 9'sh001 : $signed({1'b0, div});
		q = $signed(acc) / d;
		return q[AW-1 -: EW];
	endfunction

	// Signed sum of selected per-phase powers
	function automatic logic signed [aea_pkg::TERM_W-1:0] sel_sum(
		input logic [aea_pkg::PHASE_W-1:0] a,
		input logic [aea_pkg::PHASE_W-1:0] b,
		input logic [aea_pkg::PHASE_W-1:0] c,
		input logic [2:0] sel
	);
		logic signed [aea_pkg::TERM_W-1:0] s;
		s = '0;
		if (sel[0])
			s = s + aea_pkg::TERM_W'($signed(a));
		if (sel[1])
			s = s + aea_pkg::TERM_W'($signed(b));
		if (sel[2])
			s = s + aea_pkg::TERM_W'($signed(c));
		return s;
	endfunction

	// Sign extend a total to accumulator width
	function automatic logic [AW-1:0] sext(input logic [aea_pkg::SUM_W-1:0] v);
		return {{(AW - aea_pkg::SUM_W){v[aea_pkg::SUM_W-1]}}, v};
	endfunction

	logic signed [aea_pkg::SUM_W-1:0] total_pwr;
	logic signed [aea_pkg::SUM_W-1:0] line_pwr;

	aea_power_sum #(
		.RMS_W(RMS_W)
	) u_total (
		.v_a(V_RMS_A),
		.v_b(V_RMS_B),
		.v_c(V_RMS_C),
		.i_a(I_RMS_A),
		.i_b(I_RMS_B),
		.i_c(I_RMS_C),
		.gain_a(r_reg.gain_a),
		.gain_b(r_reg.gain_b),
		.gain_c(r_reg.gain_c),
		.formula(r_reg.app_mode[aea_pkg::FORMULA_MSB:aea_pkg::FORMULA_LSB]),
		.term_sel(r_reg.app_mode[aea_pkg::TERM_SEL_MSB:aea_pkg::TERM_SEL_LSB]),
		.total(total_pwr)
	);

	aea_power_sum #(
		.RMS_W(RMS_W)
	) u_line (
		.v_a(V_RMS_A),
		.v_b(V_RMS_B),
		.v_c(V_RMS_C),
		.i_a(I_RMS_A),
		.i_b(I_RMS_B),
		.i_c(I_RMS_C),
		.gain_a(r_reg.gain_a),
		.gain_b(r_reg.gain_b),
		.gain_c(r_reg.gain_c),
		.formula(r_reg.app_mode[aea_pkg::FORMULA_MSB:aea_pkg::FORMULA_LSB]),
		.term_sel(r_reg.app_mode[aea_pkg::LINE_SEL_MSB:aea_pkg::LINE_SEL_LSB]),
		.total(line_pwr)
	);

	logic tick;
	logic reactive;
	logic [2:0] line_act_sel;
	logic [2:0] zx_hit;
	logic [1:0] zx_inc;
	logic [aea_pkg::HC_W:0] hc_sum;
	logic cycle_done;
	logic signed [aea_pkg::TERM_W-1:0] act_sum;
	logic signed [aea_pkg::TERM_W-1:0] react_sum;
	logic [AW-1:0] line_app_in;
	logic [AW-1:0] line_act_in;
	logic [AW-1:0] line_app_new;
	logic [AW-1:0] line_act_new;
	logic [EW-1:0] app_energy;
	logic half_full;
	logic [1:0] irq_set;
	logic wr_hit;

	always_comb
	begin
		r_next = r_reg;
		tick = (r_reg.tick_cnt == aea_pkg::SAMPLE_LAST);
		reactive = r_reg.wave_mode[aea_pkg::REACTIVE_BIT];
		line_act_sel = r_reg.act_mode[aea_pkg::LINE_ACT_SEL_MSB:aea_pkg::LINE_ACT_SEL_LSB];
		r_next.tick_cnt = tick ? 4'h0 : r_reg.tick_cnt + 4'h1;

		// Continuous and read-clear accumulators
		if (tick)
		begin
			r_next.app_acc = r_reg.app_acc + sext(total_pwr);
			r_next.rc_acc = r_reg.rc_acc + sext(total_pwr);
		end
		if (REG_RD && REG_ADDR == aea_pkg::ADDR_APP_RCLR)
			r_next.rc_acc = tick ? sext(total_pwr) : '0;

		// Line accumulator sources
		act_sum = sel_sum(ACT_PWR_A, ACT_PWR_B, ACT_PWR_C, line_act_sel);
		react_sum = sel_sum(REACT_PWR_A, REACT_PWR_B, REACT_PWR_C, line_act_sel);
		if (reactive)
		begin
			line_act_in = {{(AW - aea_pkg::TERM_W){react_sum[aea_pkg::TERM_W-1]}}, react_sum};
			line_app_in = {{(AW - aea_pkg::TERM_W){1'b0}}, act_sum};
		end
		else
		begin
			line_act_in = {{(AW - aea_pkg::TERM_W){act_sum[aea_pkg::TERM_W-1]}}, act_sum};
			line_app_in = sext(line_pwr);
		end
		line_app_new = tick ? r_reg.line_app_acc + line_app_in : r_reg.line_app_acc;
		line_act_new = tick ? r_reg.line_act_acc + line_act_in : r_reg.line_act_acc;

		// Half line cycle counting
		zx_hit = ZERO_CROSS & r_reg.meas_mode[aea_pkg::ZX_SEL_MSB:aea_pkg::ZX_SEL_LSB];
		zx_inc = 2'(zx_hit[0]) + 2'(zx_hit[1]) + 2'(zx_hit[2]);
		hc_sum = {1'b0, r_reg.hc_cnt} + (aea_pkg::HC_W + 1)'(zx_inc);
		cycle_done = (r_reg.half_cyc != '0) && (hc_sum >= {1'b0, r_reg.half_cyc});
		r_next.hc_cnt = hc_sum[aea_pkg::HC_W-1:0];
		r_next.line_app_acc = line_app_new;
		r_next.line_act_acc = line_act_new;
		if (cycle_done)
		begin
			r_next.line_app_energy = div_upper(line_app_new, r_reg.divisor);
			r_next.line_act_energy = div_upper(line_act_new, r_reg.divisor);
			r_next.line_app_acc = '0;
			r_next.line_act_acc = '0;
			r_next.hc_cnt = '0;
		end

		// Half-full detection on the readable energy
		app_energy = div_upper(r_reg.app_acc, r_reg.divisor);
		half_full = app_energy[EW-1] ^ app_energy[EW-2];
		r_next.half_full_prev = half_full;
		irq_set = '0;
		irq_set[aea_pkg::IRQ_HALF_FULL] = half_full & ~r_reg.half_full_prev;
		irq_set[aea_pkg::IRQ_CYCLE_DONE] = cycle_done;

		// Register reads
		r_next.rdata = '0;
		if (REG_RD)
		begin
			case (REG_ADDR)
				aea_pkg::ADDR_MEAS_MODE: r_next.rdata = 24'(r_reg.meas_mode);
				aea_pkg::ADDR_WAVE_MODE: r_next.rdata = 24'(r_reg.wave_mode);
				aea_pkg::ADDR_ACT_MODE: r_next.rdata = 24'(r_reg.act_mode);
				aea_pkg::ADDR_APP_MODE: r_next.rdata = 24'(r_reg.app_mode);
				aea_pkg::ADDR_IRQ_EN: r_next.rdata = 24'(r_reg.irq_en);
				aea_pkg::ADDR_IRQ_STAT: r_next.rdata = 24'(r_reg.irq_stat);
				aea_pkg::ADDR_HALF_CYC: r_next.rdata = 24'(r_reg.half_cyc);
				aea_pkg::ADDR_APP_ENERGY: r_next.rdata = app_energy;
				aea_pkg::ADDR_APP_RCLR: r_next.rdata = div_upper(r_reg.rc_acc, r_reg.divisor);
				aea_pkg::ADDR_LINE_APP: r_next.rdata = r_reg.line_app_energy;
				aea_pkg::ADDR_LINE_ACT: r_next.rdata = r_reg.line_act_energy;
				aea_pkg::ADDR_DIVISOR: r_next.rdata = 24'(r_reg.divisor);
				aea_pkg::ADDR_GAIN_A: r_next.rdata = 24'(r_reg.gain_a);
				aea_pkg::ADDR_GAIN_B: r_next.rdata = 24'(r_reg.gain_b);
				aea_pkg::ADDR_GAIN_C: r_next.rdata = 24'(r_reg.gain_c);
				default: r_next.rdata = '0;
			endcase
		end

		// Status: read clears, a new event in the same cycle wins
		if (REG_RD && REG_ADDR == aea_pkg::ADDR_IRQ_STAT)
			r_next.irq_stat = irq_set;
		else
			r_next.irq_stat = r_reg.irq_stat | irq_set;

		// Register writes
		wr_hit = REG_WR;
		if (wr_hit)
		begin
			case (REG_ADDR)
				aea_pkg::ADDR_MEAS_MODE: r_next.meas_mode = REG_WDATA[7:0];
				aea_pkg::ADDR_WAVE_MODE: r_next.wave_mode = REG_WDATA[7:0];
				aea_pkg::ADDR_ACT_MODE: r_next.act_mode = REG_WDATA[7:0];
				aea_pkg::ADDR_APP_MODE: r_next.app_mode = REG_WDATA[7:0];
				aea_pkg::ADDR_IRQ_EN: r_next.irq_en = REG_WDATA[1:0];
				aea_pkg::ADDR_HALF_CYC: r_next.half_cyc = REG_WDATA[aea_pkg::HC_W-1:0];
				aea_pkg::ADDR_DIVISOR: r_next.divisor = REG_WDATA[7:0];
				aea_pkg::ADDR_GAIN_A: r_next.gain_a = REG_WDATA[aea_pkg::GAIN_W-1:0];
				aea_pkg::ADDR_GAIN_B: r_next.gain_b = REG_WDATA[aea_pkg::GAIN_W-1:0];
				aea_pkg::ADDR_GAIN_C: r_next.gain_c = REG_WDATA[aea_pkg::GAIN_W-1:0];
				default: r_next.rdata = r_next.rdata;
			endcase
		end

		if (SYS_RST)
		begin
			r_next = '0;
			r_next.wave_mode = aea_pkg::RST_WAVE_MODE;
			r_next.act_mode = aea_pkg::RST_ACT_MODE;
			r_next.app_mode = aea_pkg::RST_APP_MODE;
			r_next.meas_mode = aea_pkg::RST_MEAS_MODE;
			r_next.divisor = aea_pkg::RST_DIVISOR;
			r_next.half_cyc = aea_pkg::RST_HALF_CYC;
			r_next.irq_en = aea_pkg::RST_IRQ_EN;
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		r_reg <= r_next;
	end

	assign REG_RDATA = r_reg.rdata;
	assign ZX_ENABLE = r_reg.meas_mode[aea_pkg::ZX_SEL_MSB:aea_pkg::ZX_SEL_LSB];
	assign IRQ_N = ~|(r_reg.irq_stat & r_reg.irq_en);

endmodule // aea_top

`default_nettype wire

// *** verification/aea_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module aea_monitor (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic [5:0] REG_ADDR,
	input wire logic [23:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [23:0] REG_RDATA,
	input wire logic [2:0] ZERO_CROSS,
	input wire logic [2:0] ZX_ENABLE,
	input wire logic IRQ_N
);
	logic [7:0] div_sh, app_sh;
	logic [2:0] zx_sh;
	logic [3:0] tck;
	always_ff @(posedge CORE_CLK)
	begin
		if (SYS_RST)
		begin
			div_sh <= 8'h00;
			app_sh <= 8'h3f;
			zx_sh <= 3'h7;
			tck <= 4'h0;
		end
		else
		begin
			// Mirrors the twelve-clock sample tick
			tck <= tck == 4'hb ? 4'h0 : tck + 4'h1;
			if (REG_WR && REG_ADDR == 6'h17)
				div_sh <= REG_WDATA[7:0];
			if (REG_WR && REG_ADDR == 6'h0e)
				app_sh <= REG_WDATA[7:0];
			if (REG_WR && REG_ADDR == 6'h0b)
				zx_sh <= REG_WDATA[6:4];
		end
	end
	default clocking dc @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	chk_reset_state: assert property ($fell(SYS_RST) |-> IRQ_N && ZX_ENABLE == 3'h7)
		else $error("outputs not at reset state");
	chk_zx_follow: assert property ($stable(zx_sh) |-> ZX_ENABLE == zx_sh)
		else $error("crossing enables differ from mode bits");
	chk_div_read: assert property (REG_RD && REG_ADDR == 6'h17 |=> REG_RDATA == {16'h0, $past(div_sh)})
		else $error("divisor readback wrong");
	chk_mode_read: assert property (REG_RD && REG_ADDR == 6'h0e |=> REG_RDATA == {16'h0, $past(app_sh)})
		else $error("apparent mode readback wrong");
	chk_idle_zero: assert property (!REG_RD |=> REG_RDATA == 24'h0)
		else $error("read data not zero when idle");
	chk_unmapped_zero: assert property (REG_RD && REG_ADDR > 6'h1a |=> REG_RDATA == 24'h0)
		else $error("unmapped read not zero");
	chk_irq_cause: assert property ($fell(IRQ_N) |-> $past(|(ZERO_CROSS & ZX_ENABLE)) ||
		$past(tck == 4'h0) || $past(REG_WR && REG_ADDR == 6'h0f))
		else $error("interrupt without cause");
	chk_irq_sticky: assert property ($rose(IRQ_N) |->
		$past(REG_RD && REG_ADDR == 6'h10 || REG_WR && REG_ADDR == 6'h0f))
		else $error("interrupt released without clear");
	chk_status_set: assert property (REG_RD && REG_ADDR == 6'h10 && !IRQ_N |=> REG_RDATA != 24'h0)
		else $error("interrupt with empty status");
	cover property ($fell(IRQ_N));
	cover property (REG_RD && REG_ADDR == 6'h15);
	cover property (REG_WR && REG_ADDR == 6'h0c && REG_WDATA[5]);
endmodule // aea_monitor

bind aea_top aea_monitor u_mon (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.ZERO_CROSS(ZERO_CROSS), .ZX_ENABLE(ZX_ENABLE), .IRQ_N(IRQ_N));

`default_nettype wire

// *** verification/aea_rms_src.sv ***
`timescale 1ns/1ps
`default_nettype none

module aea_rms_src #(
	parameter int ZX_P = 60
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic upd,
	input wire logic zx_on,
	input wire logic [5:0][15:0] vi,
	input wire logic [2:0][23:0] act,
	input wire logic [2:0][23:0] rea,
	output logic [5:0][15:0] vi_q,
	output logic [2:0][23:0] act_q,
	output logic [2:0][23:0] rea_q,
	output logic [2:0] zx
);
	int cnt;
	always_ff @(posedge clk)
	begin
		zx <= 3'h0;
		cnt <= cnt + 1 == ZX_P ? 0 : cnt + 1;
		if (rst)
		begin
			cnt <= 0;
			vi_q <= '0;
			act_q <= '0;
			rea_q <= '0;
		end
		else if (upd)
		begin
			// Rms fed untrimmed, channel gains written with random values by the testbench
			vi_q <= vi;
			act_q <= act;
			rea_q <= rea;
		end
		if (zx_on && cnt + 1 == ZX_P)
			zx <= 3'h7;
	end
endmodule // aea_rms_src

`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
	$display("mismatch %0t: got %h exp %h", $time, a, b); end end

module tb;
	localparam int P = 60;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [5:0] addr = 6'h0;
	logic [23:0] wdata = 24'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic upd = 1'b0;
	logic zx_on = 1'b0;
	logic wm = 1'b0;
	logic pend = 1'b0;
	logic [23:0] rdata;
	logic [2:0] zx, zx_en;
	logic irq_n;
	logic [5:0][15:0] vi = '0;
	logic [2:0][23:0] act = '0;
	logic [2:0][23:0] rea = '0;
	logic [5:0][15:0] vi_q;
	logic [2:0][23:0] act_q, rea_q;
	logic [31:0] seed = 32'h96882395;
	logic [24:0] q[$];
	logic [24:0] exp_r;
	logic [11:0] g[3];
	logic [2:0] tsel, lsel, asel;
	logic [7:0] dv = 8'h0;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	int fm = 0;

	aea_top #(.RMS_W(16)) DUT (.CORE_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .V_RMS_A(vi_q[0]), .V_RMS_B(vi_q[1]),
		.V_RMS_C(vi_q[2]), .I_RMS_A(vi_q[3]), .I_RMS_B(vi_q[4]), .I_RMS_C(vi_q[5]),
		.ACT_PWR_A(act_q[0]), .ACT_PWR_B(act_q[1]), .ACT_PWR_C(act_q[2]), .REACT_PWR_A(rea_q[0]),
		.REACT_PWR_B(rea_q[1]), .REACT_PWR_C(rea_q[2]), .ZERO_CROSS(zx), .ZX_ENABLE(zx_en),
		.IRQ_N(irq_n));
	aea_rms_src #(.ZX_P(P)) u_src (.clk(clk), .rst(rst), .upd(upd), .zx_on(zx_on), .vi(vi),
		.act(act), .rea(rea), .vi_q(vi_q), .act_q(act_q), .rea_q(rea_q), .zx(zx));

	always #20 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic longint ph(input int k);
		longint v;
		v = k == 1 ? (fm == 1 ? (vi[0] + vi[2]) / 2 : fm == 2 ? vi[0] : vi[1]) : vi[k];
		v = (v * vi[k + 3]) >> 8;
		// Gain product floors like the arithmetic shift in hardware
		return v + ((v * $signed(g[k])) >>> 12);
	endfunction
	function automatic longint tot(input logic [2:0] s, input int w);
		longint t = 0;
		for (int k = 0; k < 3; k++)
			if (s[k]) t += w == 0 ? ph(k) : w == 1 ? act[k] : rea[k];
		return t;
	endfunction
	function automatic logic [24:0] en(input longint a);
		return {1'b0, 24'((a / (dv == 8'h0 ? 64'h1 : 64'(dv))) >> 25)};
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Bit 24 of a read note marks a value not compared
	task automatic bus(input logic w, input logic [5:0] a, input logic [24:0] d);
		addr = a;
		wdata = d[23:0];
		if (!w) q.push_back(d);
		wr_s = w;
		rd_s = !w;
		@(posedge clk);
		#1 wr_s = 1'b0;
		rd_s = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic wfall(output int n);
		n = 0;
		while (irq_n !== 1'b0 && n < 400)
		begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	task automatic line_run(input logic [7:0] mm, input logic [15:0] hc, input int per);
		int n;
		bus(1, 6'h0b, {16'h0, mm});
		bus(1, 6'h12, {8'h0, hc});
		wfall(n);
		bus(0, 6'h10, 25'h2);
		wfall(n);
		`CHK(n + 2, per)
		bus(0, 6'h10, 25'h2);
		bus(0, 6'h15, en(per / 12 * (wm ? tot(asel, 1) : tot(lsel, 0))));
		bus(0, 6'h16, en(per / 12 * tot(asel, wm ? 2 : 1)));
		$display("line run mode %h done", mm);
	endtask

	always @(posedge clk)
	begin
		pend <= rd_s;
		cyc++;
		if (cyc == 40000)
		begin
			fails++;
			stop_test();
		end
	end
	always @(negedge clk)
		if (pend)
		begin
			exp_r = q.pop_front();
			if (!exp_r[24]) `CHK(rdata, exp_r[23:0])
		end

	initial
	begin
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk);
		#1;
		bus(0, 6'h0c, 25'h0);
		bus(0, 6'h17, 25'h0);
		bus(0, 6'h12, 25'hffff);
		bus(0, 6'h0b, 25'h70);
		bus(0, 6'h0d, 25'h07);
		bus(1, 6'h13, 25'h123456);
		bus(0, 6'h13, 25'h0);
		bus(0, 6'h14, 25'h0);
		bus(0, 6'h3f, 25'h0);
		$display("reset values done");
		for (int f = 0; f < 4; f++)
		begin
			fm = f;
			for (int k = 0; k < 6; k++) vi[k] = 16'(rnd()) & (k < 3 ? 16'hfe00 : 16'hf000);
			for (int k = 0; k < 3; k++)
			begin
				g[k] = 12'(rnd());
				act[k] = 24'(rnd()) & 24'h3fffff;
				rea[k] = 24'(rnd()) & 24'h3fffff;
			end
			tsel = 3'(rnd());
			lsel = 3'(rnd());
			asel = 3'(rnd());
			dv = 8'(rnd() & 3);
			upd = 1'b1;
			bus(1, 6'h0e, {16'h0, 2'(f), lsel, tsel});
			upd = 1'b0;
			bus(1, 6'h0d, {21'h0, asel});
			for (int k = 0; k < 3; k++) bus(1, 6'h18 + 6'(k), {12'h0, g[k]});
			bus(1, 6'h17, {16'h0, dv});
			bus(0, 6'h17, {17'h0, dv});
			bus(0, 6'h0e, {17'h0, 2'(f), lsel, tsel});
			bus(0, 6'h14, 25'h1000000);
			repeat (1198) @(posedge clk);
			#1;
			bus(0, 6'h14, en(100 * tot(tsel, 0)));
			$display("formula %0d done", f);
		end
		bus(1, 6'h0f, 24'h2);
		zx_on = 1'b1;
		line_run(8'h70, 16'h6, 2 * P);
		line_run(8'h10, 16'h3, 3 * P);
		wm = 1'b1;
		bus(1, 6'h0c, 24'h20);
		line_run(8'h70, 16'h6, 2 * P);
		stop_test();
	end
endmodule // tb

`default_nettype wire
